// ---- core/slc_regs.v ----
`timescale 1ns/1ps
`default_nettype none
`include "slc_defines.vh"

// Contract
// - upper bound is loop-closure threshold with hysteresis
// - lower bound releases loop closure under hysteresis
// - ring trip compares current while ringing
// - negative common-mode speed-up threshold held
// - positive common-mode speed-up threshold held
// - either threshold exceeded selects wide bandwidth
// - fsk coefficients used only when enhanced
// - timer expiry loads space or mark coefficients
// - transitions apply rise or fall gain correction
module slc_regs #(
	parameter ADDR_W = 9,                 // byte address width
	parameter DATA_W = 16,                // indirect word width
	parameter THR_W  = 6,                 // threshold field width
	parameter VOV_W  = 4                  // overhead code width
) (
	input  wire                        ref_clk_i,
	input  wire                        srst_i,
	// avalon-mm slave
	input  wire [ADDR_W-1:0]           avs_address_i,
	input  wire                        avs_read_i,
	input  wire                        avs_write_i,
	input  wire [31:0]                 avs_writedata_i,
	input  wire [3:0]                  avs_byteenable_i,
	output wire [31:0]                 avs_readdata_o,
	output wire                        avs_waitrequest_o,
	// line measurements
	input  wire [THR_W-1:0]            loop_current_i,
	input  wire                        ringing_active_i,
	input  wire [THR_W-1:0]            cm_neg_level_i,
	input  wire [THR_W-1:0]            cm_pos_level_i,
	// oscillator one interface
	input  wire                        osc_one_active_timer_i,
	input  wire                        fsk_next_bit_i,
	input  wire [DATA_W-1:0]           osc_one_frequency_coeff_i,
	input  wire [DATA_W-1:0]           osc_one_amplitude_coeff_i,
	output wire                        osc_load_o,
	output wire [DATA_W-1:0]           osc_freq_o,
	output wire [DATA_W-1:0]           osc_amp_o,
	output wire                        gain_apply_o,
	output wire [DATA_W-1:0]           gain_corr_o,
	output wire                        fsk_active_o,
	// detector outputs
	output wire                        loop_closed_o,
	output wire                        ring_trip_o,
	output wire                        wide_bandwidth_o,
	output wire                        overhead_range_select_o,
	output wire [VOV_W-1:0]            min_overhead_voltage_code_o,
	output wire [`SLC_NSLOT*DATA_W-1:0] cfg_words_o
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	reg  [DATA_W-1:0] mem_reg [0:`SLC_NSLOT-1];  // indirect words
	reg  [7:0]        ctrl_reg;                 // control bits
	reg               ack_reg;                  // answer cycle flag
	reg  [31:0]       rdata_reg;                // read data
	reg  [31:0]       rdata_next;               // read data mux
	reg               loop_reg;                 // loop closed
	reg               rtrip_reg;                // ring trip seen
	reg               speed_reg;                // wide bandwidth
	reg               vov_bad_reg;              // overhead code too big
	reg               osc_load_reg;             // oscillator load pulse
	reg  [DATA_W-1:0] osc_freq_reg;             // loaded frequency
	reg  [DATA_W-1:0] osc_amp_reg;              // loaded amplitude
	reg               gain_apply_reg;           // gain pulse
	reg  [DATA_W-1:0] gain_corr_reg;            // gain factor
	reg               last_bit_reg;             // previous fsk bit
	reg               in_lo;                    // low bank hit
	reg               in_hi;                    // high bank hit
	reg  [6:0]        slot_wide;                // slot before trim
	wire [6:0]        idx;                      // word index
	wire [4:0]        slot;                     // storage slot
	wire              hit_mem;                  // storage hit
	wire              req;                      // any request
	wire              wr_go;                    // write commits now
	wire [7:0]        stat;                     // status word
	wire              enh;                      // enhanced fsk mode
	wire [DATA_W-1:0] wr_word;                  // lane-merged data
	integer           i;                        // reset loop index

	// ----------------------------------------
	// storage map
	// ----------------------------------------
	// slot  index  word
	//  0    1ch    loop closure upper threshold
	//  1    1dh    ring trip threshold
	//  2    1eh    common-mode low speed-up
	//  3    1fh    common-mode high speed-up
	//  4    20h    power alarm threshold pair a
	//  5    21h    power alarm threshold pair b
	//  6    22h    power alarm threshold pair c
	//  7    23h    loop closure filter coefficient
	//  8    24h    ring trip filter coefficient
	//  9    25h    thermal pole pair a
	// 10    26h    thermal pole pair b
	// 11    27h    thermal pole pair c
	// 12    28h    ringing common-mode bias
	// 13    29h    converter overhead voltage
	// 14    2ah    reserved, never written
	// 15    2bh    loop closure lower threshold
	// 16    63h    fsk space amplitude
	// 17    64h    fsk space frequency
	// 18    65h    fsk mark amplitude
	// 19    66h    fsk mark frequency
	// 20    67h    fsk rise gain correction
	// 21    68h    fsk fall gain correction
	// slot 14 still has a flop word; it stays at zero and is only
	// kept so that the flat copy has no hole in it

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	assign idx = avs_address_i[ADDR_W-1:2];

	// two banks map onto one slot range
	always @* begin
		in_lo = (idx >= `SLC_IDX_LC_UPPER) && (idx <= `SLC_IDX_LC_LOWER);
		in_hi = (idx >= `SLC_IDX_SP_AMP) && (idx <= `SLC_IDX_FSK_FALL);
		if (in_lo) begin
			slot_wide = idx - `SLC_IDX_LC_UPPER;
		end else if (in_hi) begin
			slot_wide = idx - `SLC_IDX_SP_AMP + `SLC_HI_SLOT;
		end else begin
			slot_wide = 7'h00;
		end
	end

	// outside both banks slot reads zero, but hit_mem stays low
	assign slot = slot_wide[4:0];
	// reserved slot is never stored and reads zero
	assign hit_mem = (in_lo && (idx != `SLC_IDX_RSVD)) || in_hi;

	// ----------------------------------------
	// bus handshake
	// ----------------------------------------
	// every access answers on its second cycle; simple and
	// fixed, at the price of one wait state per access
	// a request dropped in its wait cycle still raises ack, which answers a request made in the next cycle at once
	assign req               = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = req & ~ack_reg;
	assign wr_go             = avs_write_i & ack_reg;
	assign avs_readdata_o    = rdata_reg;

	// ack rises for exactly one cycle per request
	always @(posedge ref_clk_i) begin
		if (srst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req & ~ack_reg;
		end
	end

	// ----------------------------------------
	// indirect word storage
	// ----------------------------------------
	// byte lanes 0 and 1 carry the 16-bit word
	// lanes 2 and 3 carry nothing here; their enables are ignored
	assign wr_word = {
		avs_byteenable_i[1] ? avs_writedata_i[15:8] : mem_reg[slot][15:8],
		avs_byteenable_i[0] ? avs_writedata_i[7:0]  : mem_reg[slot][7:0]
	};

	// words keep their value until rewritten; they are cleared at
	// reset only so simulation is defined, software must not rely on it
	always @(posedge ref_clk_i) begin
		if (srst_i) begin
			for (i = 0; i < `SLC_NSLOT; i = i + 1) begin
				mem_reg[i] <= {DATA_W{1'b0}};
			end
		end else if (wr_go && hit_mem) begin
			mem_reg[slot] <= wr_word;
		end
	end

	// flat copy of every word for the analog side
	genvar g;
	generate
		for (g = 0; g < `SLC_NSLOT; g = g + 1) begin : g_cfg
			assign cfg_words_o[g*DATA_W +: DATA_W] = mem_reg[g];
		end
	endgenerate

	// ----------------------------------------
	// control register
	// ----------------------------------------
	// only defined bits are writable; others stay zero
	// lane 0 alone gates it; a write without lane 0 changes nothing
	always @(posedge ref_clk_i) begin
		if (srst_i) begin
			ctrl_reg <= 8'h00;
		end else if (wr_go && (idx == `SLC_IDX_CTRL) && avs_byteenable_i[0]) begin
			ctrl_reg <= avs_writedata_i[7:0] & `SLC_CTL_MASK;
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	assign stat = {2'b00, last_bit_reg, vov_bad_reg, enh, speed_reg, rtrip_reg, loop_reg};

	// status is read-only; a write to its index matches no target
	// unmapped and reserved words read as zero
	always @* begin
		rdata_next = 32'h00000000;
		if (hit_mem) begin
			rdata_next = {16'h0000, mem_reg[slot]};
		end else if (idx == `SLC_IDX_CTRL) begin
			rdata_next = {24'h000000, ctrl_reg};
		end else if (idx == `SLC_IDX_STAT) begin
			rdata_next = {24'h000000, stat};
		end
	end

	// data is caught in the wait cycle, stands in the answer cycle
	// and holds until the next read, so a late sampler still sees it
	always @(posedge ref_clk_i) begin
		if (srst_i) begin
			rdata_reg <= 32'h00000000;
		end else if (avs_read_i && !ack_reg) begin
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------
	// loop closure detector
	// ----------------------------------------
	// with hysteresis the flag sets above the upper bound and
	// clears only below the lower bound, so a noisy loop near one
	// threshold does not chatter
	always @(posedge ref_clk_i) begin
		if (srst_i) begin
			loop_reg <= 1'b0;
		end else if (ctrl_reg[`SLC_CTL_HYST]) begin
			if (loop_current_i > mem_reg[`SLC_S_LC_UPPER][THR_W-1:0]) begin
				loop_reg <= 1'b1;
			end else if (loop_current_i < mem_reg[`SLC_S_LC_LOWER][THR_W-1:0]) begin
				loop_reg <= 1'b0;
			end
		end else begin
			// single threshold when hysteresis is off
			loop_reg <= loop_current_i > mem_reg[`SLC_S_LC_UPPER][THR_W-1:0];
		end
	end

	// ----------------------------------------
	// ring trip detector
	// ----------------------------------------
	// only meaningful while the ringer runs
	// the flag drops when ringing stops; a user must latch it
	always @(posedge ref_clk_i) begin
		if (srst_i) begin
			rtrip_reg <= 1'b0;
		end else begin
			rtrip_reg <= ringing_active_i &&
				(loop_current_i > mem_reg[`SLC_S_RT_THR][THR_W-1:0]);
		end
	end

	// ----------------------------------------
	// common-mode speed-up
	// ----------------------------------------
	// either side over its limit widens the dc loop
	// no hysteresis: the flag follows the levels every cycle
	always @(posedge ref_clk_i) begin
		if (srst_i) begin
			speed_reg <= 1'b0;
		end else begin
			speed_reg <= (cm_neg_level_i > mem_reg[`SLC_S_CM_LOW][THR_W-1:0]) ||
			             (cm_pos_level_i > mem_reg[`SLC_S_CM_HIGH][THR_W-1:0]);
		end
	end

	assign wide_bandwidth_o = speed_reg;

	// ----------------------------------------
	// converter overhead code check
	// ----------------------------------------
	// the code is passed on unchanged; an out-of-range code is only
	// flagged in status, because clamping would hide a software fault
	always @(posedge ref_clk_i) begin
		if (srst_i) begin
			vov_bad_reg <= 1'b0;
		end else if (ctrl_reg[`SLC_CTL_OVR]) begin
			vov_bad_reg <= mem_reg[`SLC_S_OVH_VOLT][VOV_W-1:0] > `SLC_CONVERTER_OVERHEAD_VOLTAGE_MAX_HI;
		end else begin
			vov_bad_reg <= mem_reg[`SLC_S_OVH_VOLT][VOV_W-1:0] > `SLC_CONVERTER_OVERHEAD_VOLTAGE_MAX_LO;
		end
	end

	assign overhead_range_select_o     = ctrl_reg[`SLC_CTL_OVR];
	assign min_overhead_voltage_code_o = mem_reg[`SLC_S_OVH_VOLT][VOV_W-1:0];

	// ----------------------------------------
	// enhanced fsk coefficient loader
	// ----------------------------------------
	// enhanced mode needs both the enable and the reload bit
	assign enh = ctrl_reg[`SLC_CTL_FSK_ENHANCED_ENABLE] & ctrl_reg[`SLC_CTL_REL];

	// each timer expiry loads oscillator one; outside enhanced mode
	// the normal coefficients pass through untouched
	always @(posedge ref_clk_i) begin
		if (srst_i) begin
			osc_load_reg <= 1'b0;
			osc_freq_reg <= {DATA_W{1'b0}};
			osc_amp_reg  <= {DATA_W{1'b0}};
		end else begin
			osc_load_reg <= osc_one_active_timer_i;
			if (osc_one_active_timer_i) begin
				if (enh && fsk_next_bit_i) begin
					osc_freq_reg <= mem_reg[`SLC_S_MK_FRQ];
					osc_amp_reg  <= mem_reg[`SLC_S_MK_AMP];
				end else if (enh) begin
					osc_freq_reg <= mem_reg[`SLC_S_SP_FRQ];
					osc_amp_reg  <= mem_reg[`SLC_S_SP_AMP];
				end else begin
					osc_freq_reg <= osc_one_frequency_coeff_i;
					osc_amp_reg  <= osc_one_amplitude_coeff_i;
				end
			end
		end
	end

	// ----------------------------------------
	// fsk transition gain correction
	// ----------------------------------------
	// a bit change at an expiry picks the factor for its direction;
	// repeated bits leave the last factor and give no pulse
	// the last bit starts at zero, so a first mark counts as a rise
	always @(posedge ref_clk_i) begin
		if (srst_i) begin
			last_bit_reg   <= 1'b0;
			gain_apply_reg <= 1'b0;
			gain_corr_reg  <= {DATA_W{1'b0}};
		end else begin
			gain_apply_reg <= 1'b0;
			if (osc_one_active_timer_i && enh) begin
				last_bit_reg <= fsk_next_bit_i;
				if (fsk_next_bit_i != last_bit_reg) begin
					gain_apply_reg <= 1'b1;
					if (fsk_next_bit_i) begin
						gain_corr_reg <= mem_reg[`SLC_S_FSK_RISE];
					end else begin
						gain_corr_reg <= mem_reg[`SLC_S_FSK_FALL];
					end
				end
			end
		end
	end

	// ----------------------------------------
	// output wiring
	// ----------------------------------------
	// every output comes straight from a flip-flop except fsk_active_o, the AND of two control bits, and avs_waitrequest_o, decoded from req and ack
	assign osc_load_o    = osc_load_reg;
	assign osc_freq_o    = osc_freq_reg;
	assign osc_amp_o     = osc_amp_reg;
	assign gain_apply_o  = gain_apply_reg;
	assign gain_corr_o   = gain_corr_reg;
	assign fsk_active_o  = enh;
	assign loop_closed_o = loop_reg;
	assign ring_trip_o   = rtrip_reg;

endmodule // slc_regs

`default_nettype wire

// ---- core/slc_defines.vh ----
`ifndef SLC_DEFINES_VH
`define SLC_DEFINES_VH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define SLC_IDX_LC_UPPER   7'h1c
`define SLC_IDX_RT_THR     7'h1d
`define SLC_IDX_CM_LOW     7'h1e
`define SLC_IDX_CM_HIGH    7'h1f
`define SLC_IDX_PWR_A      7'h20
`define SLC_IDX_PWR_B      7'h21
`define SLC_IDX_PWR_C      7'h22
`define SLC_IDX_LC_FILT    7'h23
`define SLC_IDX_RT_FILT    7'h24
`define SLC_IDX_THERM_A    7'h25
`define SLC_IDX_THERM_B    7'h26
`define SLC_IDX_THERM_C    7'h27
`define SLC_IDX_RING_BIAS  7'h28
`define SLC_IDX_OVH_VOLT   7'h29
`define SLC_IDX_RSVD       7'h2a
`define SLC_IDX_LC_LOWER   7'h2b
`define SLC_IDX_SP_AMP     7'h63
`define SLC_IDX_SP_FRQ     7'h64
`define SLC_IDX_MK_AMP     7'h65
`define SLC_IDX_MK_FRQ     7'h66
`define SLC_IDX_FSK_RISE   7'h67
`define SLC_IDX_FSK_FALL   7'h68
`define SLC_IDX_CTRL       7'h70
`define SLC_IDX_STAT       7'h71

// ----------------------------------------
// storage slots
// ----------------------------------------
`define SLC_NSLOT          22
`define SLC_HI_SLOT        7'h10
`define SLC_S_LC_UPPER     0
`define SLC_S_RT_THR       1
`define SLC_S_CM_LOW       2
`define SLC_S_CM_HIGH      3
`define SLC_S_OVH_VOLT     13
`define SLC_S_LC_LOWER     15
`define SLC_S_SP_AMP       16
`define SLC_S_SP_FRQ       17
`define SLC_S_MK_AMP       18
`define SLC_S_MK_FRQ       19
`define SLC_S_FSK_RISE     20
`define SLC_S_FSK_FALL     21

// ----------------------------------------
// control and status bits
// ----------------------------------------
`define SLC_CTL_HYST       0
`define SLC_CTL_OVR        4
`define SLC_CTL_FSK_ENHANCED_ENABLE      6
`define SLC_CTL_REL        7
`define SLC_CTL_MASK       8'hd1
`define SLC_ST_LOOP        0
`define SLC_ST_RTRIP       1
`define SLC_ST_SPEED       2
`define SLC_ST_FSK         3
`define SLC_ST_VOV_BAD     4
`define SLC_ST_LAST_BIT    5

// ----------------------------------------
// field limits
// ----------------------------------------
`define SLC_CONVERTER_OVERHEAD_VOLTAGE_MAX_LO   4'h6
`define SLC_CONVERTER_OVERHEAD_VOLTAGE_MAX_HI   4'h9

`endif

// ---- tb/slc_regs_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port-level checks of the indirect bank
// ----------------------------------------
module slc_regs_chk (
	input wire logic         ref_clk_i,
	input wire logic         srst_i,
	input wire logic         avs_read_i,
	input wire logic         avs_write_i,
	input wire logic         avs_waitrequest_o,
	input wire logic [5:0]   loop_current_i,
	input wire logic         ringing_active_i,
	input wire logic [5:0]   cm_neg_level_i,
	input wire logic [5:0]   cm_pos_level_i,
	input wire logic         osc_one_active_timer_i,
	input wire logic         fsk_next_bit_i,
	input wire logic [15:0]  osc_one_frequency_coeff_i,
	input wire logic         osc_load_o,
	input wire logic [15:0]  osc_freq_o,
	input wire logic         gain_apply_o,
	input wire logic [15:0]  gain_corr_o,
	input wire logic         fsk_active_o,
	input wire logic         loop_closed_o,
	input wire logic         ring_trip_o,
	input wire logic         wide_bandwidth_o,
	input wire logic [3:0]   min_overhead_voltage_code_o,
	input wire logic [351:0] cfg_words_o
);
	// single clock domain, so one default for all
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (srst_i);

	// a held request gets exactly one wait cycle
	a_bus_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("bus request not answered after one wait cycle");
	// timer expiry always reloads oscillator one
	a_load_follows: assert property (osc_one_active_timer_i |=> osc_load_o)
		else $error("no oscillator load after timer expiry");
	a_fsk_coeff: assert property (osc_one_active_timer_i && fsk_active_o |=> osc_freq_o ==
		($past(fsk_next_bit_i) ? $past(cfg_words_o[304+:16]) : $past(cfg_words_o[272+:16])))
		else $error("enhanced reload took wrong frequency word");
	a_normal_coeff: assert property (osc_one_active_timer_i && !fsk_active_o |=>
		osc_freq_o == $past(osc_one_frequency_coeff_i))
		else $error("plain reload did not take normal coefficient");
	// correction word follows the direction of the bit change
	a_gain_dir: assert property (gain_apply_o |-> $past(osc_one_active_timer_i) && gain_corr_o ==
		($past(fsk_next_bit_i) ? $past(cfg_words_o[320+:16]) : $past(cfg_words_o[336+:16])))
		else $error("gain correction word or moment wrong");
	a_ring_trip: assert property (1'b1 |=>
		ring_trip_o == $past(ringing_active_i && loop_current_i > cfg_words_o[16+:6]))
		else $error("ring trip flag wrong");
	a_wide_bw: assert property (1'b1 |=> wide_bandwidth_o ==
		$past(cm_neg_level_i > cfg_words_o[32+:6] || cm_pos_level_i > cfg_words_o[48+:6]))
		else $error("wide bandwidth flag wrong");
	// set above upper holds in both modes; clear below both bounds too
	a_loop_set: assert property (loop_current_i > cfg_words_o[5:0] |=> loop_closed_o)
		else $error("loop closure not set above upper bound");
	a_loop_clear: assert property (loop_current_i < cfg_words_o[240+:6] && loop_current_i <= cfg_words_o[5:0]
		|=> !loop_closed_o)
		else $error("loop closure not cleared below lower bound");
	a_ovh_code: assert property ($changed(min_overhead_voltage_code_o) |->
		$past(avs_write_i && !avs_waitrequest_o))
		else $error("overhead code changed without a write");
	a_rsvd_inert: assert property (cfg_words_o[224+:16] == 16'h0000)
		else $error("reserved slot holds a value");

	c_gain: cover property (gain_apply_o);
	c_fsk_load: cover property (osc_load_o && fsk_active_o);
	c_wide: cover property (wide_bandwidth_o);
endmodule // slc_regs_chk

bind slc_regs slc_regs_chk u_chk (
	.ref_clk_i, .srst_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o, .loop_current_i,
	.ringing_active_i, .cm_neg_level_i, .cm_pos_level_i, .osc_one_active_timer_i, .fsk_next_bit_i,
	.osc_one_frequency_coeff_i, .osc_load_o, .osc_freq_o, .gain_apply_o, .gain_corr_o, .fsk_active_o,
	.loop_closed_o, .ring_trip_o, .wide_bandwidth_o, .min_overhead_voltage_code_o, .cfg_words_o
);
`default_nettype wire

// ---- tb/tb_slc_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "slc_defines.vh"
// ----------------------------------------
// self-checking bench for the indirect bank
// ----------------------------------------
module tb_slc_regs;
	logic         ref_clk_i = 1'b0;
	logic         srst_i = 1'b1;
	logic [8:0]   avs_address_i = 9'h000;
	logic         avs_read_i = 1'b0;
	logic         avs_write_i = 1'b0;
	logic [31:0]  avs_writedata_i = 32'h0;
	logic [3:0]   avs_byteenable_i = 4'hf;
	logic [5:0]   loop_current_i = 6'h00;
	logic         ringing_active_i = 1'b0;
	logic [5:0]   cm_neg_level_i = 6'h00;
	logic [5:0]   cm_pos_level_i = 6'h00;
	logic         osc_one_active_timer_i = 1'b0;
	logic         fsk_next_bit_i = 1'b0;
	logic [15:0]  osc_one_frequency_coeff_i = 16'h0;
	logic [15:0]  osc_one_amplitude_coeff_i = 16'h0;
	wire  [31:0]  avs_readdata_o;
	wire          avs_waitrequest_o, osc_load_o, gain_apply_o, fsk_active_o;
	wire          loop_closed_o, ring_trip_o, wide_bandwidth_o, overhead_range_select_o;
	wire  [15:0]  osc_freq_o, osc_amp_o, gain_corr_o;
	wire  [3:0]   min_overhead_voltage_code_o;
	wire  [351:0] cfg_words_o;
	int           error_cnt = 0;
	int           n_compared = 0;
	int           k, i, h;
	logic [15:0]  shadow [22];             // expected word per slot
	logic [31:0]  q;                       // last read data
	logic         last, lc;                // model of last fsk bit and loop state
	logic [5:0]   c, up, lo, rt, common_mode_low_speedup, common_mode_high_speedup;
	logic [7:0]   modes [4] = '{8'h00, 8'h40, 8'h80, 8'hc0};

	slc_regs dut (
		.ref_clk_i, .srst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .loop_current_i, .ringing_active_i,
		.cm_neg_level_i, .cm_pos_level_i, .osc_one_active_timer_i, .fsk_next_bit_i,
		.osc_one_frequency_coeff_i, .osc_one_amplitude_coeff_i, .osc_load_o, .osc_freq_o, .osc_amp_o,
		.gain_apply_o, .gain_corr_o, .fsk_active_o, .loop_closed_o, .ring_trip_o, .wide_bandwidth_o,
		.overhead_range_select_o, .min_overhead_voltage_code_o, .cfg_words_o
	);

	always #4 ref_clk_i = ~ref_clk_i;

	// ----------------------------------------
	// expectation helpers and compares
	// ----------------------------------------
	function automatic logic [8:0] slot_addr(input int s);
		return {(s < 16) ? 7'(`SLC_IDX_LC_UPPER + s) : 7'(`SLC_IDX_SP_AMP + s - 16), 2'b00};
	endfunction
	// strict compares; hold band only while hysteresis is on
	function automatic logic loop_next(input logic hy, input logic p, input logic [5:0] cu,
		input logic [5:0] u, input logic [5:0] l);
		if (cu > u)
			return 1'b1;
		return hy ? ((cu < l) ? 1'b0 : p) : 1'b0;
	endfunction
	task automatic conclude();
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t word got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_b(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t flag got %b exp %b", $time, got, exp);
		end
	endtask
	// request held to the edge that samples waitrequest low; data taken and request dropped there
	task automatic bus(input logic w, input logic [8:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge ref_clk_i);
		avs_address_i <= a;
		avs_read_i <= !w;
		avs_write_i <= w;
		avs_writedata_i <= {16'h0, d};
		#1;
		while (avs_waitrequest_o !== 1'b0) begin
			n++;
			if (n > 20) begin
				error_cnt++;
				conclude();
			end
			@(posedge ref_clk_i);
			#1;
		end
		@(posedge ref_clk_i);
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask
	// one timer expiry; the bit and normal coefficients go with it
	task automatic pulse(input logic b, input logic en);
		@(posedge ref_clk_i);
		osc_one_active_timer_i <= 1'b1;
		fsk_next_bit_i <= b;
		osc_one_frequency_coeff_i <= 16'($urandom);
		osc_one_amplitude_coeff_i <= 16'($urandom);
		@(posedge ref_clk_i);
		osc_one_active_timer_i <= 1'b0;
		#1;
		chk_b(osc_load_o, 1'b1);
		chk_b(fsk_active_o, en);
		chk_w(osc_freq_o, en ? (b ? shadow[19] : shadow[17]) : osc_one_frequency_coeff_i);
		chk_w(osc_amp_o, en ? (b ? shadow[18] : shadow[16]) : osc_one_amplitude_coeff_i);
		chk_b(gain_apply_o, en && b != last);
		if (en && b != last)
			chk_w(gain_corr_o, b ? shadow[20] : shadow[21]);
		if (en)
			last = b;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(44));
		repeat (4) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		// every word written first; the reserved slot must stay empty
		for (k = 0; k < 22; k++) begin
			shadow[k] = (k == 14 || k == 12) ? 16'h0 : 16'($urandom);
			bus(1'b1, slot_addr(k), (k == 14) ? 16'($urandom) : shadow[k]);
		end
		for (k = 0; k < 22; k++) begin
			bus(1'b0, slot_addr(k), 16'h0);
			chk_w(q, {16'h0, shadow[k]});
			chk_w({16'h0, cfg_words_o[16*k+:16]}, {16'h0, shadow[k]});
		end
		bus(1'b0, 9'h1fc, 16'h0);
		chk_w(q, 32'h0);
		// low lane only: the upper byte must survive
		avs_byteenable_i <= 4'h1;
		bus(1'b1, slot_addr(0), 16'h0000);
		avs_byteenable_i <= 4'hf;
		shadow[0][7:0] = 8'h00;
		bus(1'b0, slot_addr(0), 16'h0);
		chk_w(q, {16'h0, shadow[0]});
		// detectors: lower bound kept below upper so the band is real
		up = 6'd32 + 6'($urandom % 31);
		lo = 6'd1 + 6'($urandom % 31);
		rt = 6'($urandom);
		common_mode_low_speedup = 6'($urandom);
		common_mode_high_speedup = 6'($urandom);
		bus(1'b1, slot_addr(0), {10'h0, up});
		bus(1'b1, slot_addr(15), {10'h0, lo});
		bus(1'b1, slot_addr(1), {10'h0, rt});
		bus(1'b1, slot_addr(2), {10'h0, common_mode_low_speedup});
		bus(1'b1, slot_addr(3), {10'h0, common_mode_high_speedup});
		for (h = 0; h < 2; h++) begin
			bus(1'b1, {`SLC_IDX_CTRL, 2'b00}, 16'(h));
			lc = 1'b0;
			for (i = 0; i < 40; i++) begin
				case (i)
					0: c = 6'h00;
					1: c = up + 6'd1;
					2: c = up;
					3: c = lo;
					4: c = lo - 6'd1;
					default: c = 6'($urandom);
				endcase
				@(posedge ref_clk_i);
				loop_current_i <= c;
				ringing_active_i <= 1'($urandom);
				cm_neg_level_i <= 6'($urandom);
				cm_pos_level_i <= 6'($urandom);
				@(posedge ref_clk_i);
				#1;
				lc = loop_next(h[0], lc, c, up, lo);
				chk_b(loop_closed_o, lc);
				chk_b(ring_trip_o, ringing_active_i && c > rt);
				chk_b(wide_bandwidth_o, cm_neg_level_i > common_mode_low_speedup || cm_pos_level_i > common_mode_high_speedup);
			end
		end
		// top legal code of each overhead range
		for (h = 0; h < 2; h++) begin
			bus(1'b1, {`SLC_IDX_CTRL, 2'b00}, 16'(h << 4));
			bus(1'b1, slot_addr(13), h ? 16'h9 : 16'h6);
			#1;
			chk_b(overhead_range_select_o, h[0]);
			chk_w({28'h0, min_overhead_voltage_code_o}, h ? 32'h9 : 32'h6);
			bus(1'b0, {`SLC_IDX_STAT, 2'b00}, 16'h0);
			chk_b(q[`SLC_ST_VOV_BAD], 1'b0);
		end
		// reload under every pair of enable bits; only both together is enhanced
		last = 1'b0;
		for (h = 0; h < 4; h++) begin
			bus(1'b1, {`SLC_IDX_CTRL, 2'b00}, {8'h0, modes[h]});
			bus(1'b0, {`SLC_IDX_CTRL, 2'b00}, 16'h0);
			chk_w(q, {24'h0, modes[h]});
			for (i = 0; i < 8; i++)
				pulse((h == 3) ? ((i < 4) ? !i[1] : 1'($urandom)) : 1'b0, h == 3);
			bus(1'b0, {`SLC_IDX_STAT, 2'b00}, 16'h0);
			chk_b(q[`SLC_ST_FSK], h == 3);
			chk_b(q[`SLC_ST_LAST_BIT], last);
		end
		conclude();
	end
endmodule // tb_slc_regs
`default_nettype wire
